// ### design/mlb_pkg.sv
// shared types and constants for the multiplexed local bus master
package mlb_pkg;

  // bus cycle kinds requested by the core
  typedef enum logic [2:0] {
    MLB_MEM_RD,
    MLB_MEM_WR,
    MLB_IO_RD,
    MLB_IO_WR,
    MLB_INTA
  } mlb_kind_e;

  // bus cycle states
  typedef enum logic [2:0] {
    MLB_IDLE,
    MLB_T1,
    MLB_T2,
    MLB_T3,
    MLB_TW,
    MLB_T4,
    MLB_HOLD
  } mlb_state_e;

  // one bus request from the core
  typedef struct packed {
    mlb_kind_e   kind;
    logic [19:0] addr;
    logic [7:0]  wdata;
    logic [1:0]  seg;
  } mlb_req_s;

  // segment codes on the two low status bits
  localparam logic [1:0] MLB_SEG_ALT   = 2'h0;
  localparam logic [1:0] MLB_SEG_STACK = 2'h1;
  localparam logic [1:0] MLB_SEG_CODE  = 2'h2;
  localparam logic [1:0] MLB_SEG_DATA  = 2'h3;

  // field positions on the upper address/status lines
  localparam int MLB_STAT_TOP = 3;
  localparam int MLB_STAT_IE  = 2;

  // upper address bits, io cycles drive zero there in T1
  localparam logic [3:0] MLB_IO_UPPER  = 4'h0;

  // pin synchroniser depth
  localparam int MLB_SYNC_STAGES = 3;

  // reset values
  localparam logic [19:0] MLB_ADDR_RST  = 20'h00000;
  localparam logic [7:0]  MLB_BYTE_RST  = 8'h00;
  localparam logic [1:0]  MLB_SEG_RST   = MLB_SEG_CODE;

endpackage : mlb_pkg

// ### design/mlb_sync.sv
// three-stage pin synchroniser, change taken once stages two and three agree
`timescale 1ns/1ns
module mlb_sync
  import mlb_pkg::*;
(
  // clock and reset
  input  wire logic CLK,
  input  wire logic RESET_N,
  // raw pin and clean level
  input  wire logic PIN,
  output logic      LEVEL
);

  logic [MLB_SYNC_STAGES-1:0] stg_r;
  logic [MLB_SYNC_STAGES-1:0] stg_nxt;
  logic                       lvl_r;
  logic                       lvl_nxt;

  // shift chain, output follows only when last two stages agree
  always_comb begin
    stg_nxt = {stg_r[MLB_SYNC_STAGES-2:0], PIN};
    lvl_nxt = (stg_r[1] == stg_r[2]) ? stg_r[2] : lvl_r;
  end

  // registers
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      stg_r <= '0;
      lvl_r <= 1'b0;
    end else begin
      stg_r <= stg_nxt;
      lvl_r <= lvl_nxt;
    end
  end

  assign LEVEL = lvl_r;

endmodule : mlb_sync

// ### design/mlb_master.sv
// multiplexed local bus master: T1..T4 cycle engine with status and hold
//
// Overview of operation
// - low byte lines carry address in T1, data in T2, T3, Tw, T4
// - low byte lines active high, floated in interrupt acknowledge and hold
// - high address byte held valid for the whole cycle T1 to T4
// - high address byte active high, floated in interrupt acknowledge and hold
// - upper lines carry top address bits in T1 for memory, zero for io
// - upper lines carry status in T2, T3, Tw and T4 of every cycle
// - topmost status bit is always low during the status phase
// - second status bit shows interrupt enable flag, refreshed every clock
// - two low status bits encode the segment register in use
// - upper address/status lines float during hold acknowledge
// - read strobe low in T2, T3 and Tw of every read cycle
// - read strobe held high while low byte lines are driven, which ends before T2
// - io/memory select high for io, valid from T1, or from preceding T4 when a cycle follows straight on, to final T4
// - write strobe low in T2, T3 and Tw of every write cycle
`timescale 1ns/1ns
module mlb_master
  import mlb_pkg::*;
(
  // clock and reset
  input  wire logic        CLK,
  input  wire logic        RESET_N,
  // core request side
  input  wire logic        REQ_VALID,
  input  mlb_req_s         REQ,
  output logic             REQ_READY,
  output logic             DONE,
  output logic [7:0]       RDATA,
  input  wire logic        INT_EN,
  // low multiplexed address/data byte
  input  wire logic [7:0]  MUXED_LOW_BUS_IN,
  output logic [7:0]       MUXED_LOW_BUS_OUT,
  output logic             MUXED_LOW_BUS_OE,
  // high address byte
  output logic [7:0]       HIGH_ADDRESS_BYTE,
  output logic             HIGH_ADDRESS_OE,
  // upper address/status lines, bit 3 is the top
  output logic [3:0]       UPPER_ADDR_STATUS,
  output logic             UPPER_ADDR_OE,
  // strobes and select
  output logic             RD_N,
  output logic             WR_N,
  output logic             IO_M,
  output logic             STROBE_OE,
  // ready and hold
  input  wire logic        READY,
  input  wire logic        HOLD_REQ,
  output logic             HOLD_ACK
);

  mlb_state_e  st_r;
  mlb_state_e  st_nxt;
  mlb_req_s    req_r;
  mlb_req_s    req_nxt;
  logic        ad_oe_r;
  logic        ad_oe_nxt;
  logic        done_r;
  logic        done_nxt;
  logic [7:0]  rdata_r;
  logic [7:0]  rdata_nxt;
  logic        io_m_r;
  logic        io_m_nxt;
  logic        ie_r;
  logic        hold_lvl;
  logic        take;
  logic        is_rd;
  logic        is_wr;
  logic        is_io;
  logic        in_strobe;
  logic        in_status;
  logic        in_cycle;
  logic        ready_ok;

  // hold request comes from a pin
  mlb_sync u_hold_sync (
    .CLK     (CLK),
    .RESET_N (RESET_N),
    .PIN     (HOLD_REQ),
    .LEVEL   (hold_lvl)
  );

  // cycle decode
  always_comb begin
    is_rd     = (req_r.kind == MLB_MEM_RD) || (req_r.kind == MLB_IO_RD);
    is_wr     = (req_r.kind == MLB_MEM_WR) || (req_r.kind == MLB_IO_WR);
    is_io     = (req_r.kind == MLB_IO_RD) || (req_r.kind == MLB_IO_WR);
    in_strobe = (st_r == MLB_T2) || (st_r == MLB_T3) || (st_r == MLB_TW);
    in_status = in_strobe || (st_r == MLB_T4);
    in_cycle  = in_status || (st_r == MLB_T1);
    ready_ok  = READY;
    take      = REQ_VALID && !hold_lvl && ((st_r == MLB_IDLE) || (st_r == MLB_T4));
  end

  // next state of the cycle engine
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      MLB_IDLE: begin
        if (hold_lvl) begin
          st_nxt = MLB_HOLD;
        end else if (REQ_VALID) begin
          st_nxt = MLB_T1;
        end
      end
      MLB_T1: st_nxt = MLB_T2;
      MLB_T2: st_nxt = MLB_T3;
      MLB_T3: st_nxt = ready_ok ? MLB_T4 : MLB_TW;
      MLB_TW: st_nxt = ready_ok ? MLB_T4 : MLB_TW;
      MLB_T4: begin
        if (take) begin
          st_nxt = MLB_T1;
        end else if (hold_lvl) begin
          st_nxt = MLB_HOLD;
        end else begin
          st_nxt = MLB_IDLE;
        end
      end
      MLB_HOLD: st_nxt = hold_lvl ? MLB_HOLD : MLB_IDLE;
      default: st_nxt = MLB_IDLE;
    endcase
  end

  // request latch, data capture, done pulse and select
  always_comb begin
    req_nxt   = take ? REQ : req_r;
    done_nxt  = ((st_r == MLB_T3) || (st_r == MLB_TW)) && ready_ok;
    rdata_nxt = (done_nxt && !is_wr) ? MUXED_LOW_BUS_IN : rdata_r;
    io_m_nxt  = take ? ((REQ.kind == MLB_IO_RD) || (REQ.kind == MLB_IO_WR)) : io_m_r;
  end

  // low byte drive: address in T1, write data after, released for reads
  always_comb begin
    ad_oe_nxt = 1'b0;
    case (st_nxt)
      MLB_T1: ad_oe_nxt = (take ? REQ.kind : req_r.kind) != MLB_INTA;
      MLB_T2, MLB_T3, MLB_TW, MLB_T4: ad_oe_nxt = is_wr;
      default: ad_oe_nxt = 1'b0;
    endcase
  end

  // registers
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      st_r    <= MLB_IDLE;
      req_r   <= '{kind: MLB_MEM_RD, addr: MLB_ADDR_RST, wdata: MLB_BYTE_RST, seg: MLB_SEG_RST};
      ad_oe_r <= 1'b0;
      done_r  <= 1'b0;
      rdata_r <= MLB_BYTE_RST;
      io_m_r  <= 1'b0;
      ie_r    <= 1'b0;
    end else begin
      st_r    <= st_nxt;
      req_r   <= req_nxt;
      ad_oe_r <= ad_oe_nxt;
      done_r  <= done_nxt;
      rdata_r <= rdata_nxt;
      io_m_r  <= io_m_nxt;
      ie_r    <= INT_EN;
    end
  end

  // pin drive
  always_comb begin
    MUXED_LOW_BUS_OE  = ad_oe_r;
    MUXED_LOW_BUS_OUT = (st_r == MLB_T1) ? req_r.addr[7:0] : req_r.wdata;
    HIGH_ADDRESS_BYTE = req_r.addr[15:8];
    HIGH_ADDRESS_OE   = (st_r != MLB_HOLD) && !(in_cycle && req_r.kind == MLB_INTA);
    if (in_status) begin
      UPPER_ADDR_STATUS = {1'b0, ie_r, req_r.seg};
    end else begin
      UPPER_ADDR_STATUS = is_io ? MLB_IO_UPPER : req_r.addr[19:16];
    end
    UPPER_ADDR_OE = (st_r != MLB_HOLD);
    RD_N      = !(is_rd && in_strobe && !ad_oe_r);
    WR_N      = !(is_wr && in_strobe);
    IO_M      = (take && st_r == MLB_T4) ? ((REQ.kind == MLB_IO_RD) ||
                (REQ.kind == MLB_IO_WR)) : io_m_r;
    STROBE_OE = (st_r != MLB_HOLD);
    HOLD_ACK  = (st_r == MLB_HOLD);
    REQ_READY = take;
    DONE      = done_r;
    RDATA     = rdata_r;
  end

  // checks on the cycle engine
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);

  chk_state_order: assert property ((st_r == MLB_T1) |=> (st_r == MLB_T2) ##1 (st_r == MLB_T3))
    else $error("bus cycle did not run T1 T2 T3");
  chk_wait_insert: assert property (((st_r == MLB_T3) && !READY) |=> (st_r == MLB_TW))
    else $error("no wait state on low ready");
  chk_wait_steady: assert property ((st_r == MLB_TW) |-> $stable(RD_N) && $stable(WR_N)
    && $stable(MUXED_LOW_BUS_OUT))
    else $error("strobe or data moved in a wait state");
  chk_addr_phase: assert property (((st_r == MLB_T1) && (req_r.kind != MLB_INTA)) |->
    MUXED_LOW_BUS_OE && (MUXED_LOW_BUS_OUT == req_r.addr[7:0]))
    else $error("low byte not carrying address in T1");
  chk_read_float: assert property (!RD_N |-> !MUXED_LOW_BUS_OE)
    else $error("read strobe while low byte driven");
  chk_read_strobe: assert property (((st_r == MLB_T1) && is_rd) |=> !RD_N [*2])
    else $error("read strobe missing in T2 or T3");
  chk_write_strobe: assert property (((st_r == MLB_T1) && is_wr) |=> !WR_N [*2])
    else $error("write strobe missing in T2 or T3");
  chk_high_steady: assert property (((st_r == MLB_T1) ##1 in_status) |-> $stable(HIGH_ADDRESS_BYTE))
    else $error("high address byte changed inside a cycle");
  chk_io_upper: assert property (((st_r == MLB_T1) && is_io) |-> (UPPER_ADDR_STATUS == 4'h0))
    else $error("upper lines not low in io T1");
  chk_status_bits: assert property (in_status |-> !UPPER_ADDR_STATUS[MLB_STAT_TOP]
    && (UPPER_ADDR_STATUS[MLB_STAT_IE] == $past(INT_EN))
    && (UPPER_ADDR_STATUS[1:0] == req_r.seg))
    else $error("status bits wrong");
  chk_hold_float: assert property (HOLD_ACK |-> !MUXED_LOW_BUS_OE && !HIGH_ADDRESS_OE
    && !UPPER_ADDR_OE && !STROBE_OE)
    else $error("pin driven in hold acknowledge");
  chk_io_select: assert property (((st_r == MLB_T1) ##1 in_status) |-> $stable(IO_M)
    && (IO_M == is_io))
    else $error("io select wrong or unstable in cycle");

  cov_read_wait:  cover property ((st_r == MLB_T3) && is_rd ##1 (st_r == MLB_TW) ##1 (st_r == MLB_T4));
  cov_write_fast: cover property ((st_r == MLB_T3) && is_wr ##1 (st_r == MLB_T4));
  cov_hold:       cover property ((st_r == MLB_T4) ##1 (st_r == MLB_HOLD));
  cov_inta:       cover property ((st_r == MLB_T1) && (req_r.kind == MLB_INTA));
  cov_back2back:  cover property ((st_r == MLB_T4) ##1 (st_r == MLB_T1));

endmodule : mlb_master

// ### tb/mlb_far_model.sv
// far-side memory and io device model for the multiplexed local bus
`timescale 1ns/1ns
module mlb_far_model
  import mlb_pkg::*;
#(
  parameter logic [7:0] INTA_VEC = 8'h4b  // arbitrary acknowledge vector
)
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       reset_n,
  // bus pins seen from the far side
  input  wire logic       rd_n,
  input  wire logic       wr_n,
  input  wire logic       high_oe,
  input  wire logic       upper_oe,
  input  wire logic [7:0] bus_wire,
  // wait states to insert
  input  wire logic [1:0] waits,
  // what the model drives
  output logic [7:0]      drive,
  output logic            ready
);
  logic [7:0] mem_r [0:255];
  logic [7:0] addr_r;
  logic [7:0] prev_r;
  logic [7:0] last_r;
  logic [2:0] cnt_r;
  logic       strobe_d_r;
  logic       strobe;
  logic       inta;

  // an acknowledge cycle shows as floated high byte while not in hold
  assign strobe = !rd_n || !wr_n;
  assign inta   = !high_oe && upper_oe;

  // ready from the strobe or acknowledge pin decode and the counter, counted from strobe or acknowledge start
  assign ready = (strobe || inta) && (cnt_r >= 3'(waits) + (strobe ? 3'h1 : 3'h2));

  // memory data while read strobe is low, the vector in acknowledge, else a pattern that keeps moving
  assign drive = !rd_n ? mem_r[addr_r] : (inta ? INTA_VEC : ~last_r);

  // address capture, write storage and wait counting
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int j = 0; j < 256; j++) begin
        mem_r[j] <= ~8'(j);
      end
      cnt_r      <= 3'h0;
      strobe_d_r <= 1'b0;
      addr_r     <= 8'h00;
      prev_r     <= 8'h00;
      last_r     <= 8'h00;
    end else begin
      prev_r     <= bus_wire;
      last_r     <= drive;
      strobe_d_r <= strobe;
      cnt_r      <= (strobe || inta) ? cnt_r + 3'h1 : 3'h0;
      if (strobe && !strobe_d_r) begin
        addr_r <= prev_r;  // low byte held in the cycle before strobe
      end
      if (!wr_n && ready) begin
        mem_r[addr_r] <= bus_wire;
      end
    end
  end
endmodule : mlb_far_model

// ### tb/muxed_local_bus_master_bench.sv
// self-checking bench for the local bus master against a far-side model
`timescale 1ns/1ns
module muxed_local_bus_master_bench;
  import mlb_pkg::*;
  localparam logic [7:0] VEC = 8'h4b;  // arbitrary acknowledge vector
  logic       clk, reset_n, req_valid, req_ready, done, int_en, ready, hold_req, hold_ack;
  logic       bus_oe, high_oe, upper_oe, rd_n, wr_n, io_m, strobe_oe;
  logic [7:0] rdata, bus_in, bus_out, high_byte, far_drv;
  logic [3:0] upper;
  logic [1:0] waits;
  mlb_req_s   req;
  int         n_mismatch, num_checks;
  logic [7:0] exp_tbl [5] = '{8'hc3, 8'h00, 8'ha1, 8'h00, VEC};

  // wire level of the low bus: master byte while its enable is high, else the far-side byte
  assign bus_in = bus_oe ? bus_out : far_drv;

  mlb_master dut_u (.CLK(clk), .RESET_N(reset_n), .REQ_VALID(req_valid), .REQ(req),
    .REQ_READY(req_ready), .DONE(done), .RDATA(rdata), .INT_EN(int_en),
    .MUXED_LOW_BUS_IN(bus_in), .MUXED_LOW_BUS_OUT(bus_out), .MUXED_LOW_BUS_OE(bus_oe),
    .HIGH_ADDRESS_BYTE(high_byte), .HIGH_ADDRESS_OE(high_oe), .UPPER_ADDR_STATUS(upper),
    .UPPER_ADDR_OE(upper_oe), .RD_N(rd_n), .WR_N(wr_n), .IO_M(io_m), .STROBE_OE(strobe_oe),
    .READY(ready), .HOLD_REQ(hold_req), .HOLD_ACK(hold_ack));

  mlb_far_model #(.INTA_VEC(VEC)) far_u (.clk(clk), .reset_n(reset_n), .rd_n(rd_n),
    .wr_n(wr_n), .high_oe(high_oe), .upper_oe(upper_oe), .bus_wire(bus_in),
    .waits(waits), .drive(far_drv), .ready(ready));

  // 250 mhz clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // compare and count
  task chk(input logic [19:0] seen, input logic [19:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk

  // counts and verdict
  task wrap_up;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : wrap_up

  // one bus cycle, pins checked every cycle from T1 to T4
  task bus_op(input mlb_kind_e k, input logic [19:0] a, input logic [7:0] d,
              input logic [1:0] s, input logic [1:0] w, input logic [7:0] exp_rd);
    int   c;
    logic rd, wr, io, ia;
    rd = (k == MLB_MEM_RD) || (k == MLB_IO_RD);
    wr = (k == MLB_MEM_WR) || (k == MLB_IO_WR);
    io = (k == MLB_IO_RD) || (k == MLB_IO_WR);
    ia = (k == MLB_INTA);
    @(posedge clk);
    req_valid <= 1'b1;
    req       <= '{kind: k, addr: a, wdata: d, seg: s};
    waits     <= w;
    int_en    <= s[0];
    c = 0;
    do @(negedge clk); while (req_ready !== 1'b1 && ++c < 20);
    @(posedge clk);
    req_valid <= 1'b0;
    c = 0;
    do begin
      @(negedge clk);
      c++;
      chk(high_oe, !ia);
      if (!ia) chk(high_byte, a[15:8]);
      if (!ia) chk(io_m, io);
      if (c == 1) begin
        chk({bus_oe, rd_n, wr_n}, {!ia, 2'h3});
        if (!ia) chk({bus_out, upper}, {a[7:0], io ? MLB_IO_UPPER : a[19:16]});
      end else begin
        chk(upper, {1'b0, s[0], s});
        chk({rd_n, wr_n}, {!(rd && done !== 1'b1), !(wr && done !== 1'b1)});
        if (!rd_n) chk(bus_oe, 1'b0);
        if (wr) chk({bus_oe, bus_out}, {1'b1, d});
      end
    end while (done !== 1'b1 && c < 40);
    chk(20'(c), 20'(4 + int'(w)));
    if (rd || ia) chk(rdata, exp_rd);
  endtask : bus_op

  // every cycle kind and segment code, then hold, then a read back
  initial begin
    int c;
    reset_n = 1'b0;  req_valid = 1'b0;  req = '0;  int_en = 1'b0;
    hold_req = 1'b0;  waits = 2'h0;  n_mismatch = 0;  num_checks = 0;
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      bus_op(mlb_kind_e'(i), {4'(i + 9), 8'(i * 17), 8'h3c}, 8'(8'ha0 + i), 2'(i),
             2'(i % 3), exp_tbl[i]);
    end
    @(posedge clk);
    hold_req <= 1'b1;
    c = 0;
    while (hold_ack !== 1'b1 && c < 20) begin
      @(negedge clk);
      c++;
    end
    chk({hold_ack, bus_oe, high_oe, upper_oe, strobe_oe}, 5'h10);
    @(posedge clk);
    hold_req <= 1'b0;
    c = 0;
    while (hold_ack !== 1'b0 && c < 20) begin
      @(negedge clk);
      c++;
    end
    chk(hold_ack, 1'b0);
    bus_op(MLB_MEM_RD, 20'h7123c, 8'h00, MLB_SEG_DATA, 2'h1, 8'ha3);
    wrap_up();
  end

  // watchdog against a hung handshake
  initial begin
    repeat (3000) @(posedge clk);
    n_mismatch++;
    wrap_up();
  end
endmodule : muxed_local_bus_master_bench
